// >>> src/pbc4_defines.svh
// Constants for the presettable 4-bit binary counter
`ifndef PBC4_DEFINES_SVH
`define PBC4_DEFINES_SVH
`define PBC4_WIDTH 4
`define PBC4_COUNT_RESET 4'h0
`define PBC4_COUNT_FULL 4'hF
`define PBC4_COUNT_STEP 4'h1
`define PBC4_SYNC_RESET 2'h0
`endif

// >>> src/pbc4_pkg.sv
// Types shared by the presettable 4-bit binary counter
`include "pbc4_defines.svh"
package pbc4_pkg;
   typedef enum logic [1:0] {PBC4_LOAD, PBC4_COUNT, PBC4_HOLD} pbc4_mode_t;
   typedef struct packed {
      logic parallel_load_enable_low;
      logic count_enable_low;
      logic [`PBC4_WIDTH-1:0] preset_inputs;
   } pbc4_ctrl_t;
endpackage

// >>> src/pbc4_bit.sv
// One master/slave counting stage with its own assertion input and output
module pbc4_bit
   import pbc4_pkg::*;
(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic master_clear,
   input wire logic next_value,
   output logic assert_out
);
   logic slave_reg;
   logic slave_next;

   always_comb
   begin
      slave_next = next_value;
      if (master_clear)
      begin
         slave_next = 1'b0;
      end
   end

   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         slave_reg <= 1'b0;
      end
      else
      begin
         slave_reg <= slave_next;
      end
   end

   // Slave is the only visible state: the master half is the next-value net
   assign assert_out = master_clear ? 1'b0 : slave_reg;
endmodule

// >>> src/pbc4_counter.sv
// Synchronous presettable cascadable 4-bit binary up-counter
module pbc4_counter
   import pbc4_pkg::*;
(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic master_clear_pin,
   input wire logic parallel_load_enable_low_pin,
   input wire logic count_enable_low_pin,
   input wire logic [`PBC4_WIDTH-1:0] preset_inputs_pin,
   output logic [`PBC4_WIDTH-1:0] count_outputs,
   output logic terminal_count_low
);
   logic [1:0] clear_sync_reg;
   logic [1:0] clear_sync_next;
   pbc4_ctrl_t ctrl_meta_reg;
   pbc4_ctrl_t ctrl_meta_next;
   pbc4_ctrl_t ctrl_reg;
   pbc4_ctrl_t ctrl_next;
   logic master_clear;
   pbc4_mode_t mode;
   logic [`PBC4_WIDTH-1:0] count_now;
   logic [`PBC4_WIDTH-1:0] master_value;
   logic [`PBC4_WIDTH-1:0] carry_in;
   logic all_ones;
   logic count_armed;
   logic tc_reg;
   logic tc_next;

   // Pins cross in through two flops, but the terminal-count look-ahead reads the control pins after the first flop
   always_comb
   begin
      clear_sync_next = {clear_sync_reg[0], master_clear_pin};
      ctrl_meta_next.parallel_load_enable_low = parallel_load_enable_low_pin;
      ctrl_meta_next.count_enable_low = count_enable_low_pin;
      ctrl_meta_next.preset_inputs = preset_inputs_pin;
      ctrl_next = ctrl_meta_reg;
   end

   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         clear_sync_reg <= `PBC4_SYNC_RESET;
         ctrl_meta_reg <= '1;
         ctrl_reg <= '1;
      end
      else
      begin
         clear_sync_reg <= clear_sync_next;
         ctrl_meta_reg <= ctrl_meta_next;
         ctrl_reg <= ctrl_next;
      end
   end

   assign master_clear = clear_sync_reg[1];

   // Load wins over count regardless of the count enable
   always_comb
   begin
      case ({ctrl_reg.parallel_load_enable_low, ctrl_reg.count_enable_low})
         2'h0, 2'h1: mode = PBC4_LOAD;
         2'h2: mode = PBC4_COUNT;
         2'h3: mode = PBC4_HOLD;
         default: mode = PBC4_HOLD;
      endcase
   end

   // Master side: next value settles combinationally, slaves hold until the edge
   always_comb
   begin
      case (mode)
         PBC4_LOAD: master_value = ctrl_reg.preset_inputs;
         PBC4_COUNT: master_value = count_now ^ carry_in;
         PBC4_HOLD: master_value = count_now;
         default: master_value = count_now;
      endcase
   end

   // Carry lookahead: a stage toggles when every lower stage is high, so the
   // decode depth stays flat instead of rippling through an adder
   genvar c;
   generate
      for (c = 0; c < `PBC4_WIDTH; c = c + 1)
      begin : g_carry
         if (c == 0)
         begin : g_first
            assign carry_in[c] = 1'b1;
         end
         else
         begin : g_rest
            assign carry_in[c] = &count_now[c-1:0];
         end
      end
   endgenerate

   genvar i;
   generate
      for (i = 0; i < `PBC4_WIDTH; i = i + 1)
      begin : g_stage
         pbc4_bit u_stage (
            .clock(clock),
            .rst_n(rst_n),
            .master_clear(master_clear),
            .next_value(master_value[i]),
            .assert_out(count_now[i])
         );
      end
   endgenerate

   assign count_outputs = count_now;

   // Registered decode of the next state keeps terminal count in step with the outputs
   assign all_ones = (master_value == `PBC4_COUNT_FULL);

   // Enables that will act on the following edge, so a cascaded stage steps with the wrap
   assign count_armed = ctrl_next.parallel_load_enable_low && !ctrl_next.count_enable_low;

   always_comb
   begin
      tc_next = 1'b1;
      if (!master_clear && all_ones && count_armed)
      begin
         tc_next = 1'b0;
      end
   end

   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         tc_reg <= 1'b1;
      end
      else
      begin
         tc_reg <= tc_next;
      end
   end

   assign terminal_count_low = master_clear ? 1'b1 : tc_reg;
endmodule

// >>> tb/pbc4_counter_asserts.sv
// Port-level properties of the 4-bit counter
module pbc4_counter_asserts
   import pbc4_pkg::*;
(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic master_clear_pin,
   input wire logic parallel_load_enable_low_pin,
   input wire logic count_enable_low_pin,
   input wire logic [3:0] preset_inputs_pin,
   input wire logic [3:0] count_outputs,
   input wire logic terminal_count_low
);
   timeunit 1ns;
   timeprecision 1ns;
   wire logic mc = master_clear_pin;
   wire logic ld = parallel_load_enable_low_pin;
   wire logic ce = count_enable_low_pin;
   wire logic [3:0] q = count_outputs;
   wire logic tc = terminal_count_low;
   default clocking @(posedge clock);
   endclocking
   default disable iff (!rst_n);
   // Four samples cover the two sync flops plus the acting edge
   a_load_counting: assert property ((!mc && !ld && !ce)[*4] |-> q == $past(preset_inputs_pin, 3))
      else $error("load while counting wrong");
   a_load_holding: assert property ((!mc && !ld && ce)[*4] |-> q == $past(preset_inputs_pin, 3))
      else $error("load while holding wrong");
   a_count_step: assert property ((!mc && ld && !ce)[*4] |-> q == $past(q) + 4'h1)
      else $error("count step wrong");
   a_hold_value: assert property ((!mc && ld && ce)[*4] |-> $stable(q))
      else $error("hold changed count");
   a_clear_zero: assert property (mc[*3] |-> q == 4'h0)
      else $error("clear left count");
   a_clear_tc: assert property (mc[*3] |-> tc)
      else $error("clear left tc low");
   a_tc_decode: assert property ((!mc && ld && !ce)[*4] |-> tc == (q != 4'hF))
      else $error("tc decode wrong");
   a_tc_idle: assert property ((!mc && (!ld || ce))[*4] |-> tc)
      else $error("tc low without counting");
endmodule

// >>> tb/pbc4_next_stage.sv
// Cascaded next counter stage enabled by the terminal-count output
module pbc4_next_stage
   import pbc4_pkg::*;
(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic count_enable_low,
   output logic [3:0] count_high
);
   timeunit 1ns;
   timeprecision 1ns;
   always @(posedge clock)
      if (!rst_n)
         count_high <= 4'h0;
      else if (!count_enable_low)
         count_high <= count_high + 4'h1;
endmodule

// >>> tb/pbc4_counter_test.sv
// Random self-checking bench for the 4-bit counter with a cascaded stage
module pbc4_counter_test
   import pbc4_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic mc = 1'b0;
   pbc4_ctrl_t ctl = '0;
   logic [3:0] q, hi, cnt = 4'h0, him = 4'h0;
   logic tc, tcm = 1'b1;
   logic [6:0] e;
   logic [6:0] sq[$] = '{7'h00, 7'h00};
   logic [31:0] x = 32'h825F;
   int hold = 0, err_count = 0, checks_done = 0;
   always #25 clock = ~clock;
   pbc4_counter pbc4_counter_inst (.clock, .rst_n, .master_clear_pin(mc),
      .parallel_load_enable_low_pin(ctl.parallel_load_enable_low),
      .count_enable_low_pin(ctl.count_enable_low), .preset_inputs_pin(ctl.preset_inputs),
      .count_outputs(q), .terminal_count_low(tc));
   pbc4_next_stage pbc4_next_stage_inst (.clock, .rst_n, .count_enable_low(tc), .count_high(hi));
   function automatic logic [31:0] xs(logic [31:0] v);
      v ^= v << 13;
      v ^= v >> 17;
      v ^= v << 5;
      return v;
   endfunction
   task automatic check(logic [3:0] s, logic [3:0] w);
      checks_done++;
      if (s !== w)
      begin
         err_count++;
         $display("ERROR %0t seen %h expected %h", $time, s, w);
      end
   endtask
   task automatic finish_test;
      $display("checks %0d errors %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // Model: e is the synced stage acting on this edge, sq[0] the one acting on the next edge
   always @(posedge clock)
      if (!rst_n)
      begin
         sq = '{7'h00, 7'h00};
         cnt = 4'h0;
         tcm = 1'b1;
         him = 4'h0;
      end
      else
      begin
         if (!tcm)
            him = him + 4'h1;
         e = sq.pop_front();
         sq.push_back({mc, ctl});
         if (e[6])
            cnt = 4'h0;
         else if (!e[5])
            cnt = e[3:0];
         else if (!e[4])
            cnt = cnt + 4'h1;
         // Terminal count looks ahead to the enables that act on the next edge
         tcm = !(sq[0][5] && !sq[0][4] && cnt == 4'hF) || sq[0][6];
      end
   always @(negedge clock)
   begin
      check(q, sq[0][6] ? 4'h0 : cnt);
      check({3'h0, tc}, {3'h0, tcm});
      check(hi, him);
      if (hold == 0)
      begin
         x = xs(x);
         mc <= x[7:4] == 4'h0;
         ctl <= {x[8] | x[9], x[4:0]};
         hold = x[13:11];
      end
      else
         hold--;
   end
   initial
   begin
      repeat (8) @(posedge clock);
      @(negedge clock) rst_n <= 1'b1;
      repeat (4000) @(posedge clock);
      $display("random traffic test done");
      finish_test;
   end
endmodule
bind pbc4_counter pbc4_counter_asserts pbc4_counter_asserts_inst (.clock, .rst_n,
   .master_clear_pin, .parallel_load_enable_low_pin, .count_enable_low_pin,
   .preset_inputs_pin, .count_outputs, .terminal_count_low);
